// [design/rtcha_defs.svh]
// constants for the rtc host access block
`ifndef RTCHA_DEFS_SVH
`define RTCHA_DEFS_SVH
// ---------------------------------------------
// timing
// ---------------------------------------------
`define RTCHA_CLK_NS 10
`define RTCHA_QTR_NS 250000000
`define RTCHA_HINIT_NS 1500000000
`define RTCHA_GAP_NS 1000000
`define RTCHA_ROUND_NS 122100
`define RTCHA_INIT_QTR 3'h4
`define RTCHA_TMO_QTR 3'h3
// ---------------------------------------------
// device register indices
// ---------------------------------------------
`define RTCHA_A_SEC 4'h0
`define RTCHA_A_MIN 4'h1
`define RTCHA_A_HOUR 4'h2
`define RTCHA_A_WDAY 4'h3
`define RTCHA_A_DAY 4'h4
`define RTCHA_A_MON 4'h5
`define RTCHA_A_YEAR 4'h6
`define RTCHA_A_AMIN 4'h8
`define RTCHA_A_AHOUR 4'h9
`define RTCHA_A_AWDAY 4'ha
`define RTCHA_A_BMIN 4'hb
`define RTCHA_A_BHOUR 4'hc
`define RTCHA_A_BWDAY 4'hd
`define RTCHA_A_CTL1 4'he
`define RTCHA_A_CTL2 4'hf
// ---------------------------------------------
// device fields and codes
// ---------------------------------------------
`define RTCHA_B_ALARM_A_EN 7
`define RTCHA_B_ALARM_B_EN 6
`define RTCHA_B_SEC_ADJUST 5
`define RTCHA_B_HALT_FLAG 4
`define RTCHA_B_PER_FLAG 2
`define RTCHA_B_ALARM_A_FLAG 1
`define RTCHA_B_ALARM_B_FLAG 0
`define RTCHA_CT_LOW 3'h1
`define RTCHA_CT_P2HZ 3'h2
`define RTCHA_CT_P1HZ 3'h3
`define RTCHA_CT_SEC 3'h4
`define RTCHA_CT_MIN 3'h5
`define RTCHA_CT_HOUR 3'h6
`define RTCHA_CT_MON 3'h7
`define RTCHA_R_DAY 5'h01
`define RTCHA_R_MON 4'h1
// ---------------------------------------------
// host apb map
// ---------------------------------------------
`define RTCHA_H_CTRL 12'h000
`define RTCHA_H_STAT 12'h004
`define RTCHA_H_IST 12'h008
`define RTCHA_H_IMASK 12'h00c
`define RTCHA_H_BUF 7'h01
`define RTCHA_C_GO 0
`define RTCHA_C_RD 1
`define RTCHA_C_ADDR 4
`define RTCHA_C_CNT 8
`endif

// [design/rtcha_pkg.sv]
// types shared by the rtc host access block
package rtcha_pkg;
	// ---------------------------------------------
	// device state
	// ---------------------------------------------
	typedef struct packed {
		logic s1, s2;
		logic [1:0] strap;
		logic [2:0] ini;
		logic busy;
		logic [1:0] phase;
		logic open;
		logic [2:0] age;
		logic pend;
		logic [5:0] sec, min;
		logic [4:0] hour;
		logic [2:0] wday;
		logic [4:0] day;
		logic [3:0] month;
		logic [6:0] year;
		logic [5:0] amin, bmin;
		logic [4:0] ahour, bhour;
		logic [7:0] awday, bwday;
		logic alarm_a_enable_bit, alarm_b_enable_bit;
		logic [2:0] ct;
		logic periodic_interrupt_flag, alarm_a_flag, alarm_b_flag, oscillation_halt_flag;
		logic resp, ack;
		logic [7:0] rdata;
		logic wake_n, first_n;
	} rtcha_dev_t;
	// ---------------------------------------------
	// host state
	// ---------------------------------------------
	typedef enum logic [2:0] {
		RTCHA_S_INIT, RTCHA_S_IDLE, RTCHA_S_START, RTCHA_S_XFER,
		RTCHA_S_WAIT, RTCHA_S_STOP, RTCHA_S_GAP
	} rtcha_st_t;
	typedef struct packed {
		rtcha_st_t st;
		logic [31:0] cnt;
		logic [3:0] tries;
		logic [2:0] idx, last;
		logic dir, err;
		logic [3:0] base;
		logic [7:0][7:0] data;
		logic start, stop, wr, rd;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic pready, pslverr;
		logic [31:0] prdata;
		logic [2:0] ist, imask;
		logic irq, wake_q;
	} rtcha_host_t;
	// divider state
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} rtcha_tick_t;
endpackage

// [design/rtcha_if.sv]
// link between the rtc device end and its host end
`timescale 1ns/100ps
interface rtcha_if;
	logic start, stop, wr, rd; // host pulses
	logic [3:0] addr; // register index
	logic [7:0] wdata; // write byte
	logic resp, ack; // device answer pulse, ack level
	logic [7:0] rdata; // read byte
	logic wake_n, first_n; // interrupt outputs, low active
	modport dev (input start, stop, wr, rd, addr, wdata,
		output resp, ack, rdata, wake_n, first_n);
	modport host (output start, stop, wr, rd, addr, wdata,
		input resp, ack, rdata, wake_n, first_n);
endinterface

// [design/rtcha_tick.sv]
// one-cycle enable pulse every DIV clocks
`timescale 1ns/100ps
module rtcha_tick #(
	parameter int DIV = 4
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// enable out
	output logic o_tick
);
	rtcha_pkg::rtcha_tick_t r_reg, r_next;

	if (DIV < 2)
	begin : g_bad
		$error("DIV must be at least 2");
	end

	// count down, pulse at wrap
	always_comb
	begin
		r_next = r_reg;
		r_next.tick = (r_reg.cnt == 32'h0);
		r_next.cnt = r_next.tick ? 32'(DIV - 1) : r_reg.cnt - 32'h1;
	end

	// register
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign o_tick = r_reg.tick;
endmodule

// [design/rtcha_dev.sv]
// device end: clock calendar, alarms, periodic and wake outputs
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`include "rtcha_defs.svh"
`timescale 1ns/100ps
module rtcha_dev #(
	parameter int QTR_CYC = `RTCHA_QTR_NS / `RTCHA_CLK_NS
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// link to host
	rtcha_if.dev lk,
	// user side
	input wire logic i_backup,
	output logic o_init_busy
);
	// adjust must finish in one clock, far inside its limit
	localparam int ROUND_CYC = `RTCHA_ROUND_NS / `RTCHA_CLK_NS;
	if (ROUND_CYC < 1 || QTR_CYC < 2)
	begin : g_bad
		$error("clock too slow for this block");
	end

	rtcha_pkg::rtcha_dev_t r_reg, r_next; // all state
	logic qtick; // quarter second enable
	logic sec_evt; // seconds count-up due
	logic sec_adjust; // seconds adjust request
	logic adv; // advance time now
	logic lvl; // level mode event
	logic per; // periodic drive
	logic sec0; // new second is zero

	// ---------------------------------------------
	// quarter second divider
	// ---------------------------------------------
	rtcha_tick #(
		.DIV(QTR_CYC)
	) i_rtcha_tick (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.o_tick(qtick)
	);

	// days in a month, leap every fourth year
	function automatic logic [4:0] mdays(input logic [3:0] m, input logic [6:0] y);
		logic [4:0] d;
		d = 5'h1f;
		if (m == 4'h2)
			d = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
		else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb)
			d = 5'h1e;
		return d;
	endfunction

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb
	begin
		r_next = r_reg;
		r_next.resp = 1'b0;
		sec_adjust = 1'b0;
		adv = 1'b0;
		lvl = 1'b0;
		per = 1'b0;
		// strap sync, read once after release
		r_next.s1 = i_backup;
		r_next.s2 = r_reg.s1;
		if (r_reg.strap != 2'h3)
			r_next.strap = r_reg.strap + 2'h1;
		if (r_reg.strap == 2'h2)
			r_next.oscillation_halt_flag = ~r_reg.s2;
		// init window after reset
		if (qtick && r_reg.ini != `RTCHA_INIT_QTR)
			r_next.ini = r_reg.ini + 3'h1;
		r_next.busy = (r_next.ini != `RTCHA_INIT_QTR);
		if (qtick)
			r_next.phase = r_reg.phase + 2'h1;
		sec_evt = qtick && r_reg.phase == 2'h3;
		// transaction window and forced end
		if (r_reg.open && qtick)
		begin
			r_next.age = r_reg.age + 3'h1;
			if (r_reg.age == `RTCHA_TMO_QTR - 3'h1)
				r_next.open = 1'b0;
		end
		if (lk.stop)
			r_next.open = 1'b0;
		if (lk.start && !r_reg.busy)
		begin
			r_next.open = 1'b1;
			r_next.age = 3'h0;
		end
		// byte access: nack and ff outside an open window
		if (lk.wr || lk.rd)
		begin
			r_next.resp = 1'b1;
			r_next.ack = r_reg.open && !r_reg.busy;
			r_next.rdata = 8'hff;
		end
		if (lk.rd && r_next.ack)
		begin
			case (lk.addr)
				`RTCHA_A_SEC: r_next.rdata = {2'h0, r_reg.sec};
				`RTCHA_A_MIN: r_next.rdata = {2'h0, r_reg.min};
				`RTCHA_A_HOUR: r_next.rdata = {3'h0, r_reg.hour};
				`RTCHA_A_WDAY: r_next.rdata = {5'h0, r_reg.wday};
				`RTCHA_A_DAY: r_next.rdata = {3'h0, r_reg.day};
				`RTCHA_A_MON: r_next.rdata = {4'h0, r_reg.month};
				`RTCHA_A_YEAR: r_next.rdata = {1'h0, r_reg.year};
				`RTCHA_A_AMIN: r_next.rdata = {2'h0, r_reg.amin};
				`RTCHA_A_AHOUR: r_next.rdata = {3'h0, r_reg.ahour};
				`RTCHA_A_AWDAY: r_next.rdata = r_reg.awday;
				`RTCHA_A_BMIN: r_next.rdata = {2'h0, r_reg.bmin};
				`RTCHA_A_BHOUR: r_next.rdata = {3'h0, r_reg.bhour};
				`RTCHA_A_BWDAY: r_next.rdata = r_reg.bwday;
				`RTCHA_A_CTL1: r_next.rdata = {r_reg.alarm_a_enable_bit, r_reg.alarm_b_enable_bit,
					3'h0, r_reg.ct};
				`RTCHA_A_CTL2: r_next.rdata = {3'h0, r_reg.oscillation_halt_flag, 1'b0,
					r_reg.periodic_interrupt_flag, r_reg.alarm_a_flag, r_reg.alarm_b_flag};
				default: r_next.rdata = 8'h00;
			endcase
		end
		if (lk.wr && r_next.ack)
		begin
			case (lk.addr)
				`RTCHA_A_SEC: r_next.sec = lk.wdata[5:0];
				`RTCHA_A_MIN: r_next.min = lk.wdata[5:0];
				`RTCHA_A_HOUR: r_next.hour = lk.wdata[4:0];
				`RTCHA_A_WDAY: r_next.wday = lk.wdata[2:0];
				`RTCHA_A_DAY: r_next.day = lk.wdata[4:0];
				`RTCHA_A_MON: r_next.month = lk.wdata[3:0];
				`RTCHA_A_YEAR: r_next.year = lk.wdata[6:0];
				`RTCHA_A_AMIN: r_next.amin = lk.wdata[5:0];
				`RTCHA_A_AHOUR: r_next.ahour = lk.wdata[4:0];
				`RTCHA_A_AWDAY: r_next.awday = lk.wdata;
				`RTCHA_A_BMIN: r_next.bmin = lk.wdata[5:0];
				`RTCHA_A_BHOUR: r_next.bhour = lk.wdata[4:0];
				`RTCHA_A_BWDAY: r_next.bwday = lk.wdata;
				`RTCHA_A_CTL1:
				begin
					r_next.alarm_a_enable_bit = lk.wdata[`RTCHA_B_ALARM_A_EN];
					r_next.alarm_b_enable_bit = lk.wdata[`RTCHA_B_ALARM_B_EN];
					r_next.ct = lk.wdata[2:0];
					sec_adjust = lk.wdata[`RTCHA_B_SEC_ADJUST];
				end
				`RTCHA_A_CTL2:
				begin
					// zero clears a periodic or alarm flag, one keeps it; the halt flag always clears
					r_next.periodic_interrupt_flag = r_reg.periodic_interrupt_flag
						& lk.wdata[`RTCHA_B_PER_FLAG];
					r_next.alarm_a_flag = r_reg.alarm_a_flag & lk.wdata[`RTCHA_B_ALARM_A_FLAG];
					r_next.alarm_b_flag = r_reg.alarm_b_flag & lk.wdata[`RTCHA_B_ALARM_B_FLAG];
					r_next.oscillation_halt_flag = 1'b0;
				end
				default:
				begin
				end
			endcase
		end
		// round seconds to the nearest minute at once
		if (sec_adjust)
		begin
			if (r_next.sec < 6'h1e)
				r_next.sec = 6'h00;
			else
			begin
				r_next.sec = 6'h3b;
				adv = 1'b1;
			end
		end
		// hold count-ups while a transaction is open
		if (sec_evt && r_next.open)
			r_next.pend = 1'b1;
		if ((sec_evt || r_reg.pend) && !r_next.open)
		begin
			adv = 1'b1;
			r_next.pend = 1'b0;
		end
		// counter chain
		if (adv)
		begin
			if (r_next.sec >= 6'h3b)
			begin
				r_next.sec = 6'h00;
				if (r_next.min >= 6'h3b)
				begin
					r_next.min = 6'h00;
					if (r_next.hour >= 5'h17)
					begin
						r_next.hour = 5'h00;
						r_next.wday = (r_next.wday >= 3'h6) ? 3'h0 : r_next.wday + 3'h1;
						if (r_next.day >= mdays(r_next.month, r_next.year))
						begin
							r_next.day = `RTCHA_R_DAY;
							if (r_next.month >= 4'hc)
							begin
								r_next.month = `RTCHA_R_MON;
								r_next.year = (r_next.year >= 7'h63) ? 7'h00 : r_next.year + 7'h1;
							end
							else
								r_next.month = r_next.month + 4'h1;
						end
						else
							r_next.day = r_next.day + 5'h01;
					end
					else
						r_next.hour = r_next.hour + 5'h01;
				end
				else
					r_next.min = r_next.min + 6'h01;
			end
			else
				r_next.sec = r_next.sec + 6'h01;
		end
		// events are set after clears, so a set wins
		sec0 = adv && r_next.sec == 6'h00;
		case (r_reg.ct)
			`RTCHA_CT_SEC: lvl = adv;
			`RTCHA_CT_MIN: lvl = sec0;
			`RTCHA_CT_HOUR: lvl = sec0 && r_next.min == 6'h00;
			`RTCHA_CT_MON: lvl = sec0 && r_next.min == 6'h00 && r_next.hour == 5'h00 && r_next.day == 5'h01;
			default: lvl = 1'b0;
		endcase
		if (lvl)
			r_next.periodic_interrupt_flag = 1'b1;
		if (r_next.alarm_a_enable_bit && sec0 && r_next.min == r_next.amin && r_next.hour == r_next.ahour
			&& r_next.awday[r_next.wday])
			r_next.alarm_a_flag = 1'b1;
		if (r_next.alarm_b_enable_bit && sec0 && r_next.min == r_next.bmin && r_next.hour == r_next.bhour
			&& r_next.bwday[r_next.wday])
			r_next.alarm_b_flag = 1'b1;
		// periodic waveform; pulse modes fall at count-up
		case (r_next.ct)
			`RTCHA_CT_LOW: per = 1'b1;
			`RTCHA_CT_P2HZ: per = ~r_next.phase[0];
			`RTCHA_CT_P1HZ: per = ~r_next.phase[1];
			default: per = r_next.ct[2] & r_next.periodic_interrupt_flag;
		endcase
		r_next.wake_n = ~((r_next.alarm_b_enable_bit & r_next.alarm_b_flag) | per);
		r_next.first_n = ~(r_next.alarm_a_enable_bit & r_next.alarm_a_flag);
	end

	// ---------------------------------------------
	// register
	// ---------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			r_reg <= '0;
			r_reg.day <= `RTCHA_R_DAY;
			r_reg.month <= `RTCHA_R_MON;
			r_reg.oscillation_halt_flag <= 1'b1;
			r_reg.busy <= 1'b1;
			r_reg.wake_n <= 1'b1;
			r_reg.first_n <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	// outputs straight from flops
	assign lk.resp = r_reg.resp;
	assign lk.ack = r_reg.ack;
	assign lk.rdata = r_reg.rdata;
	assign lk.wake_n = r_reg.wake_n;
	assign lk.first_n = r_reg.first_n;
	assign o_init_busy = r_reg.busy;
endmodule

// [design/rtcha_host.sv]
// host end: apb command registers driving burst transactions
`include "rtcha_defs.svh"
`timescale 1ns/100ps
module rtcha_host #(
	parameter int INIT_CYC = `RTCHA_HINIT_NS / `RTCHA_CLK_NS,
	parameter int GAP_CYC = `RTCHA_GAP_NS / `RTCHA_CLK_NS,
	parameter int RETRY_MAX = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// link to device
	rtcha_if.host lk,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// interrupt
	output logic o_irq
);
	if (INIT_CYC < 1 || GAP_CYC < 1 || RETRY_MAX < 1 || RETRY_MAX > 15)
	begin : g_bad
		$error("host parameter out of range");
	end

	rtcha_pkg::rtcha_host_t r_reg, r_next; // all state
	logic [2:0] ev; // done, fail, wake events
	logic acc; // apb access completes

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb
	begin
		r_next = r_reg;
		r_next.start = 1'b0;
		r_next.stop = 1'b0;
		r_next.wr = 1'b0;
		r_next.rd = 1'b0;
		ev = 3'h0;
		ev[2] = r_reg.wake_q & ~lk.wake_n;
		r_next.wake_q = lk.wake_n;
		acc = i_psel && i_penable && r_reg.pready;
		// setup cycle: decode and latch answer
		if (i_psel && !i_penable)
		begin
			r_next.pready = 1'b1;
			r_next.pslverr = 1'b0;
			r_next.prdata = 32'h0;
			if (i_paddr == `RTCHA_H_CTRL)
				r_next.prdata = {21'h0, r_reg.last, r_reg.base, 2'h0, r_reg.dir, 1'b0};
			else if (i_paddr == `RTCHA_H_STAT)
				r_next.prdata = {20'h0, r_reg.tries, 5'h0, ~r_reg.wake_q,
					r_reg.st == rtcha_pkg::RTCHA_S_INIT, r_reg.st != rtcha_pkg::RTCHA_S_IDLE};
			else if (i_paddr == `RTCHA_H_IST)
				r_next.prdata = {29'h0, r_reg.ist};
			else if (i_paddr == `RTCHA_H_IMASK)
				r_next.prdata = {29'h0, r_reg.imask};
			else if (i_paddr[11:5] == `RTCHA_H_BUF && i_paddr[1:0] == 2'h0)
				r_next.prdata = {24'h0, r_reg.data[i_paddr[4:2]]};
			else
				r_next.pslverr = 1'b1;
		end
		// access edge: writes take effect
		if (acc)
		begin
			r_next.pready = 1'b0;
			r_next.pslverr = 1'b0;
			if (i_pwrite && !r_reg.pslverr)
			begin
				if (i_paddr == `RTCHA_H_CTRL)
				begin
					if (i_pwdata[`RTCHA_C_GO] && r_reg.st == rtcha_pkg::RTCHA_S_IDLE)
					begin
						r_next.dir = i_pwdata[`RTCHA_C_RD];
						r_next.base = i_pwdata[`RTCHA_C_ADDR +: 4];
						r_next.last = i_pwdata[`RTCHA_C_CNT +: 3];
						r_next.tries = 4'h0;
						r_next.st = rtcha_pkg::RTCHA_S_START;
					end
				end
				else if (i_paddr == `RTCHA_H_IST)
					r_next.ist = r_reg.ist & ~i_pwdata[2:0];
				else if (i_paddr == `RTCHA_H_IMASK)
					r_next.imask = i_pwdata[2:0];
				else if (i_paddr[11:5] == `RTCHA_H_BUF)
					r_next.data[i_paddr[4:2]] = i_pwdata[7:0];
			end
		end
		// transaction sequencer
		case (r_reg.st)
			rtcha_pkg::RTCHA_S_INIT:
			begin
				// let the device start up first
				if (r_reg.cnt == 32'(INIT_CYC - 1))
					r_next.st = rtcha_pkg::RTCHA_S_IDLE;
				else
					r_next.cnt = r_reg.cnt + 32'h1;
			end
			rtcha_pkg::RTCHA_S_START:
			begin
				r_next.start = 1'b1;
				r_next.idx = 3'h0;
				r_next.err = 1'b0;
				r_next.st = rtcha_pkg::RTCHA_S_XFER;
			end
			rtcha_pkg::RTCHA_S_XFER:
			begin
				// whole burst inside one start/stop, a few clocks long
				r_next.wr = ~r_reg.dir;
				r_next.rd = r_reg.dir;
				r_next.addr = r_reg.base + {1'b0, r_reg.idx};
				r_next.wdata = r_reg.data[r_reg.idx];
				r_next.st = rtcha_pkg::RTCHA_S_WAIT;
			end
			rtcha_pkg::RTCHA_S_WAIT:
			begin
				if (lk.resp)
				begin
					if (!lk.ack || (r_reg.dir && lk.rdata == 8'hff))
					begin
						r_next.err = 1'b1;
						r_next.st = rtcha_pkg::RTCHA_S_STOP;
					end
					else
					begin
						if (r_reg.dir)
							r_next.data[r_reg.idx] = lk.rdata;
						if (r_reg.idx == r_reg.last)
							r_next.st = rtcha_pkg::RTCHA_S_STOP;
						else
						begin
							r_next.idx = r_reg.idx + 3'h1;
							r_next.st = rtcha_pkg::RTCHA_S_XFER;
						end
					end
				end
			end
			rtcha_pkg::RTCHA_S_STOP:
			begin
				r_next.stop = 1'b1;
				if (!r_reg.err)
				begin
					ev[0] = 1'b1;
					r_next.st = rtcha_pkg::RTCHA_S_IDLE;
				end
				else if (r_reg.tries == 4'(RETRY_MAX))
				begin
					ev[1] = 1'b1;
					r_next.st = rtcha_pkg::RTCHA_S_IDLE;
				end
				else
				begin
					// repeat the whole access after a pause
					r_next.tries = r_reg.tries + 4'h1;
					r_next.cnt = 32'h0;
					r_next.st = rtcha_pkg::RTCHA_S_GAP;
				end
			end
			rtcha_pkg::RTCHA_S_GAP:
			begin
				if (r_reg.cnt == 32'(GAP_CYC - 1))
					r_next.st = rtcha_pkg::RTCHA_S_START;
				else
					r_next.cnt = r_reg.cnt + 32'h1;
			end
			default:
			begin
			end
		endcase
		// sticky status, set wins over clear
		r_next.ist = r_next.ist | ev;
		r_next.irq = |(r_next.ist & r_next.imask);
	end

	// ---------------------------------------------
	// register
	// ---------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			r_reg <= '0;
			r_reg.wake_q <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	// outputs straight from flops
	assign lk.start = r_reg.start;
	assign lk.stop = r_reg.stop;
	assign lk.wr = r_reg.wr;
	assign lk.rd = r_reg.rd;
	assign lk.addr = r_reg.addr;
	assign lk.wdata = r_reg.wdata;
	assign o_pready = r_reg.pready;
	assign o_prdata = r_reg.prdata;
	assign o_pslverr = r_reg.pslverr;
	assign o_irq = r_reg.irq;
endmodule

// [sim/rtcha_checker.sv]
// link checker for the rtc host access block
`timescale 1ns/100ps
module rtcha_checker (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// host requests
	input wire logic i_start,
	input wire logic i_stop,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	// device answers
	input wire logic i_resp,
	input wire logic i_ack,
	input wire logic [7:0] i_rdata,
	input wire logic i_wake_n,
	input wire logic i_first_n
);
	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// answer one cycle after each request
	property p_resp_after_req; (i_wr || i_rd) |=> i_resp; endproperty
	a_resp_after_req: assert property (p_resp_after_req) else $error("no answer after request");
	// no answer without a request
	property p_resp_cause; i_resp |-> $past(i_wr || i_rd); endproperty
	a_resp_cause: assert property (p_resp_cause) else $error("answer without request");
	// refused read returns all ones
	property p_refused_ff; (i_rd ##1 (i_resp && !i_ack)) |-> i_rdata == 8'hff; endproperty
	a_refused_ff: assert property (p_refused_ff) else $error("refused read not ff");
	// answer fields hold between answers
	property p_answer_holds; !i_resp |-> $stable(i_ack) && $stable(i_rdata); endproperty
	a_answer_holds: assert property (p_answer_holds) else $error("answer changed");
	// both interrupt outputs released after reset
	property p_idle_at_reset; $rose(i_rstn) |-> i_wake_n && i_first_n; endproperty
	a_idle_at_reset: assert property (p_idle_at_reset) else $error("interrupt active at reset");
	// start alone, never write with read
	property p_one_request; !(i_wr && i_rd) && !(i_start && (i_wr || i_rd || i_stop)); endproperty
	a_one_request: assert property (p_one_request) else $error("requests overlap");
	// start is a lone pulse
	property p_start_pulse; i_start |=> !i_start [*2]; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start repeated");
	// next request waits past the answer
	property p_gap_after_resp; i_resp |-> !i_wr && !i_rd && !i_start; endproperty
	a_gap_after_resp: assert property (p_gap_after_resp) else $error("request during answer");
	// main scenarios seen
	c_write_ok: cover property (i_resp && i_ack && $past(i_wr));
	c_refused: cover property (i_resp && !i_ack);
	c_wake: cover property ($fell(i_wake_n));
	c_release: cover property ($rose(i_wake_n));
endmodule

// [sim/rtcha_bench.sv]
// testbench for the rtc host access block, both ends joined
`include "rtcha_defs.svh"
`timescale 1ns/100ps
module rtcha_bench;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic i_clk, i_rstn, i_backup; // clock, reset, backup pin
	logic psel, penable, pwrite; // apb control
	logic [11:0] paddr; // apb address
	logic [31:0] pwdata, prdata, q; // apb data, last read
	logic pready, pslverr, irq, init_busy, err_q; // design outputs
	int fails, compares; // counters
	localparam logic [7:0] TV [0:6] = '{8'h00, 8'h05, 8'h0a, 8'h02, 8'h0f, 8'h06, 8'h18};
	rtcha_if lk();
	rtcha_dev #(.QTR_CYC(40)) i_rtcha_dev (.i_clk(i_clk), .i_rstn(i_rstn), .lk(lk.dev), .i_backup(i_backup),
		.o_init_busy(init_busy));
	// host init shorter than device init, so early accesses are refused and retried
	rtcha_host #(.INIT_CYC(100), .GAP_CYC(20), .RETRY_MAX(8)) i_rtcha_host (.i_clk(i_clk), .i_rstn(i_rstn),
		.lk(lk.host), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_irq(irq));
	rtcha_checker i_rtcha_checker (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(lk.start), .i_stop(lk.stop),
		.i_wr(lk.wr), .i_rd(lk.rd), .i_addr(lk.addr), .i_wdata(lk.wdata), .i_resp(lk.resp), .i_ack(lk.ack),
		.i_rdata(lk.rdata), .i_wake_n(lk.wake_n), .i_first_n(lk.first_n));
	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// buffer word address
	function automatic logic [11:0] ba(input int i);
		return {`RTCHA_H_BUF, 5'(4 * i)};
	endfunction
	// read and compare masked
	task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	// device burst once the host is idle, waits for done or fail
	task go(input logic dir, input logic [3:0] idx, input logic [2:0] last);
		q = 32'h3;
		while (q[1:0] != 2'h0)
			apb(1'b0, `RTCHA_H_STAT, 32'h0);
		apb(1'b1, `RTCHA_H_CTRL, {21'h0, last, idx, 2'h0, dir, 1'b1});
		q = 32'h0;
		for (int n = 0; n < 400 && q[1:0] == 2'h0; n++)
			apb(1'b0, `RTCHA_H_IST, 32'h0);
		chk({30'h0, q[1:0]}, 32'h1);
		apb(1'b1, `RTCHA_H_IST, 32'h3);
	endtask
	// write one device byte
	task wr1(input logic [3:0] idx, input logic [7:0] b);
		apb(1'b1, ba(0), {24'h0, b});
		go(1'b0, idx, 3'h0);
	endtask
	// set whole time block in one transaction
	task set_time(input logic [7:0] s);
		for (int i = 0; i < 7; i++)
			apb(1'b1, ba(i), {24'h0, (i == 0) ? s : TV[i]});
		go(1'b0, `RTCHA_A_SEC, 3'h6);
	endtask
	// poll wake status bit
	task wait_wake(input logic b);
		q = 32'h0;
		q[2] = ~b;
		for (int n = 0; n < 300 && q[2] !== b; n++)
			apb(1'b0, `RTCHA_H_STAT, 32'h0);
		chk({31'h0, q[2]}, {31'h0, b});
	endtask
	// verdict
	task finish_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ---------------------------------------------
	// clock, watchdog, tests
	// ---------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial
	begin
		repeat (60000) @(posedge i_clk);
		fails++;
		finish_test;
	end
	initial
	begin
		{i_rstn, i_backup, psel, penable, pwrite, paddr, pwdata, fails, compares} = '0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		chk({31'h0, init_busy}, 32'h1);
		rchk(`RTCHA_H_STAT, 32'h2, 32'h2);
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, err_q}, 32'h1);
		// cold start: retried read, halt flag set, then cleared by any ctl2 write
		go(1'b1, `RTCHA_A_CTL2, 3'h0);
		apb(1'b0, `RTCHA_H_STAT, 32'h0);
		chk({31'h0, q[11:8] != 4'h0}, 32'h1);
		rchk(ba(0), 32'hff, 32'h10);
		wr1(`RTCHA_A_CTL2, 8'hff);
		go(1'b1, `RTCHA_A_CTL2, 3'h0);
		rchk(ba(0), 32'hff, 32'h0);
		// time block written and read whole
		set_time(8'h00);
		go(1'b1, `RTCHA_A_SEC, 3'h6);
		for (int i = 1; i < 7; i++)
			rchk(ba(i), 32'hff, {24'h0, TV[i]});
		rchk(ba(0), 32'hfc, 32'h0);
		// periodic level mode every second, unmasked interrupt
		apb(1'b1, `RTCHA_H_IMASK, 32'h4);
		wr1(`RTCHA_A_CTL1, {5'h0, `RTCHA_CT_SEC});
		wait_wake(1'b1);
		rchk(`RTCHA_H_IST, 32'h4, 32'h4);
		chk({31'h0, irq}, 32'h1);
		wr1(`RTCHA_A_CTL2, 8'h03);
		rchk(`RTCHA_H_STAT, 32'h4, 32'h0);
		wr1(`RTCHA_A_CTL1, 8'h00);
		apb(1'b1, `RTCHA_H_IST, 32'h4);
		rchk(`RTCHA_H_IST, 32'h4, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `RTCHA_H_IMASK, 32'h0);
		// alarms a and b armed while disabled, reached through seconds adjust
		for (int i = 0; i < 6; i++)
			apb(1'b1, ba(i), (i % 3 == 0) ? 32'h6 : ((i % 3 == 1) ? {24'h0, TV[2]} : 32'h4));
		go(1'b0, `RTCHA_A_AMIN, 3'h5);
		set_time(8'd40);
		wr1(`RTCHA_A_CTL1, 8'hc0);
		rchk(`RTCHA_H_STAT, 32'h4, 32'h0);
		chk({31'h0, lk.first_n}, 32'h1);
		wr1(`RTCHA_A_CTL1, 8'he0);
		wait_wake(1'b1);
		chk({31'h0, lk.first_n}, 32'h0);
		go(1'b1, `RTCHA_A_MIN, 3'h0);
		rchk(ba(0), 32'hff, 32'h6);
		rchk(`RTCHA_H_IST, 32'h4, 32'h4);
		chk({31'h0, irq}, 32'h0);
		go(1'b1, `RTCHA_A_CTL2, 3'h0);
		rchk(ba(0), 32'h7, 32'h3);
		// alarm a acknowledged alone, alarm b kept
		wr1(`RTCHA_A_CTL2, 8'h05);
		chk({31'h0, lk.first_n}, 32'h1);
		rchk(`RTCHA_H_STAT, 32'h4, 32'h4);
		go(1'b1, `RTCHA_A_CTL2, 3'h0);
		rchk(ba(0), 32'h7, 32'h1);
		wr1(`RTCHA_A_CTL2, 8'h06);
		rchk(`RTCHA_H_STAT, 32'h4, 32'h0);
		// restart with backup supply leaves the halt flag clear
		i_backup <= 1'b1;
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		go(1'b1, `RTCHA_A_CTL2, 3'h0);
		rchk(ba(0), 32'hff, 32'h0);
		finish_test;
	end
endmodule
